// file: aux_dio_pkg.sv
// Constants, register map and carrier types for the auxiliary digital I/O block.
// Assumes a single 100 MHz clock; times become cycle counts here, except the sync width limits, which stay in microseconds.
package aux_dio_pkg;

	// ----------------------------------------
	// Clock and times
	// ----------------------------------------
	localparam int CLK_PERIOD_NS   = 10;
	localparam int TRANS_PULSE_NS  = 190000;
	localparam int FUNC_PULSE_NS   = 2000000;
	localparam int TRANS_PULSE_CYC = TRANS_PULSE_NS / CLK_PERIOD_NS;
	localparam int FUNC_PULSE_CYC  = FUNC_PULSE_NS / CLK_PERIOD_NS;
	localparam int US_NS           = 1000;
	localparam int US_CYC          = US_NS / CLK_PERIOD_NS;
	localparam int SYNC_W_MIN_US   = 3;
	localparam int SYNC_W_MAX_US   = 100000;
	localparam int SHOW_MS         = 1000;
	localparam int BLINK_MS        = 3000;
	localparam int MS_CYC          = 1000000 / CLK_PERIOD_NS;
	localparam int SHOW_CYC        = SHOW_MS * MS_CYC;
	localparam int BLINK_CYC       = BLINK_MS * MS_CYC;
	localparam int REF_LOSS_MS     = 100;
	localparam int REF_LOSS_CYC    = REF_LOSS_MS * MS_CYC;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] CTRL_OFS       = 8'h00;
	localparam logic [7:0] SYNC_WIDTH_OFS = 8'h04;
	localparam logic [7:0] DO_CFG_OFS     = 8'h08;
	localparam logic [7:0] DI_FILT_OFS    = 8'h0C;
	localparam logic [7:0] DI_ACT_OFS     = 8'h10;
	localparam logic [7:0] PHASE_OFS_OFS  = 8'h14;
	localparam logic [7:0] FREQ_SET_OFS   = 8'h18;
	localparam logic [7:0] RANGE_OFS      = 8'h1C;
	localparam logic [7:0] SPEED_OFS      = 8'h20;
	localparam logic [7:0] STATUS_OFS     = 8'h24;
	localparam logic [7:0] DI_EVENT_OFS   = 8'h28;

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	localparam int CTRL_TRANS_EN   = 0;
	localparam int CTRL_OUTCHG_EN  = 1;
	localparam int CTRL_SETPT_EN   = 2;
	localparam int CTRL_SYNC_OUT   = 3;
	localparam int CTRL_SYNC_POL   = 4;
	localparam int CTRL_SYNC_AUTO  = 5;
	localparam int CTRL_SYNC_IN    = 6;
	localparam int CTRL_W          = 7;

	// ----------------------------------------
	// Reset values and lock tolerance
	// ----------------------------------------
	localparam logic [6:0]  CTRL_RST       = 7'h00;
	localparam logic [16:0] SYNC_WIDTH_RST = 17'h0_0064;
	localparam logic [31:0] FREQ_SET_RST   = 32'h0000_0A7C;
	localparam logic [30:0] RANGE_RST      = 31'h0000_01BF;
	localparam logic [3:0]  SPEED_RST      = 4'h8;
	localparam logic [31:0] LOCK_TOL       = 32'h0100_0000;

	// Digital output sources
	typedef enum logic [2:0] {
		SRC_MANUAL   = 3'b000,
		SRC_OUT_ON   = 3'b001,
		SRC_PHASE_SRC = 3'b010,
		SRC_FAULT    = 3'b011,
		SRC_TRANS    = 3'b100,
		SRC_PROGRAM  = 3'b101,
		SRC_REMOTE   = 3'b110,
		SRC_COUPLING = 3'b111
	} do_src_t;

	// Levels reported by the rest of the instrument
	typedef struct packed {
		logic coupling_type_source;
		logic remote;
		logic program_active;
		logic transient_active;
		logic fault;
		logic phase_source_a;
		logic output_on;
	} dev_status_t;

	// Setpoint change pulses
	typedef struct packed {
		logic volt;
		logic freq;
		logic wave;
		logic angle;
	} setpt_chg_t;

endpackage

// file: di_filter.sv
// Input synchroniser and stability filter for one user digital input.
// Assumes tick_us pulses once per microsecond in the mclk domain.
`timescale 1ns/1ns
module di_filter (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// Time base and setting
	input  wire logic       tick_us,
	input  wire logic [7:0] len_us,
	// Pin and filtered level
	input  wire logic       din,
	output logic            dout
);

	logic       s1_r;
	logic       s2_r;
	logic [7:0] cnt_r;
	logic       differ;
	logic       settled;

	assign differ  = s2_r != dout;
	assign settled = differ && cnt_r >= len_us;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
		end
	end

	// Level must hold len_us before it is taken
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 8'h00;
			dout  <= 1'b0;
		end else begin
			if (!differ || settled)
				cnt_r <= 8'h00;
			else if (tick_us && cnt_r != 8'hFF)
				cnt_r <= cnt_r + 8'h01;
			if (settled)
				dout <= s2_r;
		end
	end

endmodule // di_filter

// file: aux_dio.sv
// Auxiliary digital I/O: trigger strobe, phase sync output, sync engine,
// user digital outputs and filtered user inputs.
// Assumes a register master with one-cycle strobes and read data next cycle.
`timescale 1ns/1ns

module aux_dio #(
	parameter int TRANS_CYC = aux_dio_pkg::TRANS_PULSE_CYC,
	parameter int FUNC_CYC  = aux_dio_pkg::FUNC_PULSE_CYC,
	parameter int SHOW_CYC  = aux_dio_pkg::SHOW_CYC,
	parameter int BLINK_CYC = aux_dio_pkg::BLINK_CYC,
	parameter int LOSS_CYC  = aux_dio_pkg::REF_LOSS_CYC,
	parameter int US_CYC    = aux_dio_pkg::US_CYC
) (
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rst_n,
	// Register port
	input  wire logic [7:0]               addr,
	input  wire logic [31:0]              wdata,
	input  wire logic                     wr,
	input  wire logic                     rd,
	output logic [31:0]                   rdata,
	// Instrument events and state
	input  wire logic                     transient_start,
	input  wire aux_dio_pkg::setpt_chg_t  setpt_chg,
	input  wire aux_dio_pkg::dev_status_t dev_status,
	// External sync reference
	input  wire logic                     sync_ref,
	// Strobe and sync outputs
	output logic                          trig_out,
	output logic                          sync_out,
	output logic [31:0]                   phase_a,
	// Status indication
	output logic                          show_synced,
	output logic                          show_unsynced,
	// User digital outputs 1 and 2 (push-pull)
	output logic [1:0]                    user_out,
	// User digital outputs 3 and 4 (open drain)
	output logic                          relay_drive_out_a_o,
	output logic                          relay_drive_out_a_oe,
	output logic                          relay_drive_out_b_o,
	output logic                          relay_drive_out_b_oe,
	// User digital inputs and edge actions
	input  wire logic [2:0]               user_in,
	output logic [2:0]                    rise_act,
	output logic [2:0]                    fall_act
);

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [6:0]  ctrl_r;
	logic [16:0] sync_width_r;
	logic [19:0] do_cfg_r;
	logic [23:0] di_filt_r;
	logic [23:0] di_act_r;
	logic [31:0] phase_ofs_r;
	logic [31:0] frequency_setpoint_r;
	logic [30:0] sync_tracking_range_r;
	logic [3:0]  speed_r;
	logic [5:0]  di_event_r;
	logic [31:0] status_w;
	logic [31:0] rd_mux;

	logic        wr_ctrl;
	logic        wr_sw;
	logic        wr_do;
	logic        wr_df;
	logic        wr_da;
	logic        wr_ph;
	logic        wr_fs;
	logic        wr_rg;
	logic        wr_sp;
	logic        wr_ev;

	assign wr_ctrl = wr && addr == aux_dio_pkg::CTRL_OFS;
	assign wr_sw   = wr && addr == aux_dio_pkg::SYNC_WIDTH_OFS;
	assign wr_do   = wr && addr == aux_dio_pkg::DO_CFG_OFS;
	assign wr_df   = wr && addr == aux_dio_pkg::DI_FILT_OFS;
	assign wr_da   = wr && addr == aux_dio_pkg::DI_ACT_OFS;
	assign wr_ph   = wr && addr == aux_dio_pkg::PHASE_OFS_OFS;
	assign wr_fs   = wr && addr == aux_dio_pkg::FREQ_SET_OFS;
	assign wr_rg   = wr && addr == aux_dio_pkg::RANGE_OFS;
	assign wr_sp   = wr && addr == aux_dio_pkg::SPEED_OFS;
	assign wr_ev   = wr && addr == aux_dio_pkg::DI_EVENT_OFS;

	// Independent strobe enables, plus sync settings
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r                <= aux_dio_pkg::CTRL_RST;
			sync_width_r          <= aux_dio_pkg::SYNC_WIDTH_RST;
			do_cfg_r              <= 20'h0_0000;
			di_filt_r             <= 24'h00_0000;
			di_act_r              <= 24'h00_0000;
			phase_ofs_r           <= 32'h0000_0000;
			frequency_setpoint_r  <= aux_dio_pkg::FREQ_SET_RST;
			sync_tracking_range_r <= aux_dio_pkg::RANGE_RST;
			speed_r               <= aux_dio_pkg::SPEED_RST;
		end else begin
			if (wr_ctrl) ctrl_r <= wdata[6:0];
			if (wr_sw) sync_width_r <= wdata[16:0];
			if (wr_do) do_cfg_r <= wdata[19:0];
			if (wr_df) di_filt_r <= wdata[23:0];
			if (wr_da) di_act_r <= wdata[23:0];
			if (wr_ph) phase_ofs_r <= wdata;
			if (wr_fs) frequency_setpoint_r <= wdata;
			if (wr_rg) sync_tracking_range_r <= wdata[30:0];
			if (wr_sp) speed_r <= wdata[3:0];
		end
	end

	always_comb begin
		case (addr)
			aux_dio_pkg::CTRL_OFS:       rd_mux = {25'h000_0000, ctrl_r};
			aux_dio_pkg::SYNC_WIDTH_OFS: rd_mux = {15'h0000, sync_width_r};
			aux_dio_pkg::DO_CFG_OFS:     rd_mux = {12'h000, do_cfg_r};
			aux_dio_pkg::DI_FILT_OFS:    rd_mux = {8'h00, di_filt_r};
			aux_dio_pkg::DI_ACT_OFS:     rd_mux = {8'h00, di_act_r};
			aux_dio_pkg::PHASE_OFS_OFS:  rd_mux = phase_ofs_r;
			aux_dio_pkg::FREQ_SET_OFS:   rd_mux = frequency_setpoint_r;
			aux_dio_pkg::RANGE_OFS:      rd_mux = {1'b0, sync_tracking_range_r};
			aux_dio_pkg::SPEED_OFS:      rd_mux = {28'h000_0000, speed_r};
			aux_dio_pkg::STATUS_OFS:     rd_mux = status_w;
			aux_dio_pkg::DI_EVENT_OFS:   rd_mux = {26'h000_0000, di_event_r};
			default:                     rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			rdata <= 32'h0000_0000;
		else if (rd)
			rdata <= rd_mux;
		else
			rdata <= 32'h0000_0000;
	end

	// ----------------------------------------
	// Trigger output / function strobe
	// ----------------------------------------
	logic [17:0] trig_cnt_r;
	logic        out_on_q_r;
	logic        ev_trans;
	logic        ev_func;

	assign ev_trans = ctrl_r[aux_dio_pkg::CTRL_TRANS_EN] && transient_start;
	// Relay change or any setpoint change
	assign ev_func  = (ctrl_r[aux_dio_pkg::CTRL_OUTCHG_EN] && dev_status.output_on != out_on_q_r)
	                || (ctrl_r[aux_dio_pkg::CTRL_SETPT_EN] && |setpt_chg);

	// Width depends on cause; a new event restarts the pulse
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			out_on_q_r <= 1'b0;
			trig_cnt_r <= 18'h0_0000;
			trig_out   <= 1'b0;
		end else begin
			out_on_q_r <= dev_status.output_on;
			if (ev_func) begin
				trig_cnt_r <= 18'(FUNC_CYC);
				trig_out   <= 1'b1;
			end else if (ev_trans) begin
				trig_cnt_r <= 18'(TRANS_CYC);
				trig_out   <= 1'b1;
			end else begin
				trig_out   <= trig_cnt_r > 18'h0_0001;
				if (trig_cnt_r != 18'h0_0000)
					trig_cnt_r <= trig_cnt_r - 18'h0_0001;
			end
		end
	end

	// ----------------------------------------
	// Sync engine (phase A generator)
	// ----------------------------------------
	logic        ref_s1_r;
	logic        ref_s2_r;
	logic        ref_s3_r;
	logic        ref_edge;
	logic [31:0] acc_r;
	logic [32:0] acc_sum;
	logic        wrap;
	logic signed [31:0] corr_r;
	logic signed [31:0] err;
	logic signed [31:0] step;
	logic signed [32:0] corr_sum;
	logic signed [32:0] lim;
	logic signed [31:0] corr_nxt;
	logic [31:0] err_abs;
	logic        locked_r;
	logic [23:0] loss_cnt_r;
	logic        sync_in_en;

	assign sync_in_en = ctrl_r[aux_dio_pkg::CTRL_SYNC_IN];
	assign ref_edge   = ref_s2_r && !ref_s3_r;
	assign acc_sum    = {1'b0, acc_r} + {1'b0, frequency_setpoint_r + 32'(corr_r)};
	assign wrap       = acc_sum[32];
	assign phase_a    = acc_r;
	// Reference edge should land at the programmed phase
	assign err        = signed'(phase_ofs_r - acc_r);
	// Speed sets loop gain; larger code tracks slower
	assign step       = err >>> ({1'b0, speed_r} + 5'h08);
	assign corr_sum   = 33'(corr_r) + 33'(step);
	assign lim        = signed'({2'b00, sync_tracking_range_r});
	// Clamp to setpoint plus or minus range
	assign corr_nxt   = corr_sum > lim ? 32'(lim)
	                  : corr_sum < -lim ? 32'(-lim) : corr_sum[31:0];
	assign err_abs    = err[31] ? 32'(-err) : 32'(err);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ref_s1_r <= 1'b0;
			ref_s2_r <= 1'b0;
			ref_s3_r <= 1'b0;
		end else begin
			ref_s1_r <= sync_ref;
			ref_s2_r <= ref_s1_r;
			ref_s3_r <= ref_s2_r;
		end
	end

	// Correction holds when the reference vanishes, still inside the clamp
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			acc_r      <= 32'h0000_0000;
			corr_r     <= 32'sh0000_0000;
			locked_r   <= 1'b0;
			loss_cnt_r <= 24'h00_0000;
		end else begin
			acc_r <= acc_sum[31:0];
			if (!sync_in_en) begin
				corr_r     <= 32'sh0000_0000;
				locked_r   <= 1'b0;
				loss_cnt_r <= 24'h00_0000;
			end else if (ref_edge) begin
				corr_r     <= corr_nxt;
				locked_r   <= err_abs < aux_dio_pkg::LOCK_TOL;
				loss_cnt_r <= 24'h00_0000;
			end else if (loss_cnt_r >= 24'(LOSS_CYC)) begin
				locked_r   <= 1'b0;
			end else begin
				loss_cnt_r <= loss_cnt_r + 24'h00_0001;
			end
		end
	end

	// ----------------------------------------
	// Status indication
	// ----------------------------------------
	logic [31:0] blink_r;

	// Synced shown one second of every three
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			blink_r       <= 32'h0000_0000;
			show_synced   <= 1'b0;
			show_unsynced <= 1'b0;
		end else begin
			if (!locked_r || blink_r >= 32'(BLINK_CYC - 1))
				blink_r <= 32'h0000_0000;
			else
				blink_r <= blink_r + 32'h0000_0001;
			show_synced   <= locked_r && blink_r < 32'(SHOW_CYC);
			show_unsynced <= sync_in_en && !locked_r;
		end
	end

	// ----------------------------------------
	// Phase sync output
	// ----------------------------------------
	logic [16:0] width_us;
	logic [23:0] sp_cnt_r;
	logic        sp_level;

	assign width_us = sync_width_r < 17'(aux_dio_pkg::SYNC_W_MIN_US) ? 17'(aux_dio_pkg::SYNC_W_MIN_US)
	                : sync_width_r > 17'(aux_dio_pkg::SYNC_W_MAX_US) ? 17'(aux_dio_pkg::SYNC_W_MAX_US)
	                : sync_width_r;
	// Auto mode gives half-period square wave
	assign sp_level = ctrl_r[aux_dio_pkg::CTRL_SYNC_AUTO] ? !acc_r[31] : sp_cnt_r != 24'h00_0000;

	// Start a pulse at each phase A wrap
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sp_cnt_r <= 24'h00_0000;
			sync_out <= 1'b0;
		end else begin
			if (wrap && ctrl_r[aux_dio_pkg::CTRL_SYNC_OUT])
				sp_cnt_r <= 24'(width_us) * 24'(US_CYC);
			else if (sp_cnt_r != 24'h00_0000)
				sp_cnt_r <= sp_cnt_r - 24'h00_0001;
			sync_out <= (ctrl_r[aux_dio_pkg::CTRL_SYNC_OUT] && sp_level)
			            ^ ctrl_r[aux_dio_pkg::CTRL_SYNC_POL];
		end
	end

	// ----------------------------------------
	// User digital outputs
	// ----------------------------------------
	logic [3:0] do_r;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_do
			logic [7:0] src_vec;
			logic [2:0] sel;
			assign src_vec = {dev_status.coupling_type_source, dev_status.remote,
			                  dev_status.program_active, dev_status.transient_active,
			                  dev_status.fault, dev_status.phase_source_a,
			                  dev_status.output_on, do_cfg_r[16 + gi]};
			assign sel     = do_cfg_r[4*gi +: 3];
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n)
					do_r[gi] <= 1'b0;
				else
					do_r[gi] <= src_vec[sel] ^ do_cfg_r[4*gi + 3];
			end
		end
	endgenerate

	// Open drain: pull low for 0, release to the pull-up for 1
	assign user_out             = do_r[1:0];
	assign relay_drive_out_a_o  = 1'b0;
	assign relay_drive_out_a_oe = !do_r[2];
	assign relay_drive_out_b_o  = 1'b0;
	assign relay_drive_out_b_oe = !do_r[3];

	// ----------------------------------------
	// User digital inputs
	// ----------------------------------------
	logic [6:0] us_cnt_r;
	logic       tick_us;
	logic [2:0] di_f;
	logic [2:0] di_q_r;
	logic [2:0] rise_ev;
	logic [2:0] fall_ev;

	assign tick_us = us_cnt_r == 7'(US_CYC - 1);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			us_cnt_r <= 7'h00;
		else if (tick_us)
			us_cnt_r <= 7'h00;
		else
			us_cnt_r <= us_cnt_r + 7'h01;
	end

	generate
		for (gi = 0; gi < 3; gi++) begin : g_di
			di_filter u_filt (
				.mclk    (mclk),
				.rst_n   (rst_n),
				.tick_us (tick_us),
				.len_us  (di_filt_r[8*gi +: 8]),
				.din     (user_in[gi]),
				.dout    (di_f[gi])
			);
			// Edge acts only if its own code is nonzero
			assign rise_ev[gi] = di_f[gi] && !di_q_r[gi] && di_act_r[4*gi +: 4] != 4'h0;
			assign fall_ev[gi] = !di_f[gi] && di_q_r[gi] && di_act_r[12 + 4*gi +: 4] != 4'h0;
		end
	endgenerate

	// Sticky events: a new edge beats a write-one-to-clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			di_q_r     <= 3'h0;
			rise_act   <= 3'h0;
			fall_act   <= 3'h0;
			di_event_r <= 6'h00;
		end else begin
			di_q_r     <= di_f;
			rise_act   <= rise_ev;
			fall_act   <= fall_ev;
			di_event_r <= (di_event_r & ~(wr_ev ? wdata[5:0] : 6'h00)) | {fall_ev, rise_ev};
		end
	end

	assign status_w = {20'h0_0000, show_unsynced, show_synced, locked_r, di_f, do_r,
	                   sync_out, trig_out};

endmodule // aux_dio

// file: aux_dio_props.sv
// Checker for the auxiliary digital I/O block, seen from its top ports.
// Assumes the package register map and shortened pulse counts.
`timescale 1ns/1ns
module aux_dio_props #(
	parameter int TRANS_CYC = 19,
	parameter int FUNC_CYC  = 200,
	parameter int SHOW_CYC  = 30
) (
	// Clock, reset and register writes
	input	wire logic			mclk,
	input	wire logic			rst_n,
	input	wire logic [7:0]		addr,
	input	wire logic [31:0]		wdata,
	input	wire logic			wr,
	// Events and state
	input	wire logic			transient_start,
	input	wire aux_dio_pkg::setpt_chg_t	setpt_chg,
	input	wire aux_dio_pkg::dev_status_t	dev_status,
	// Outputs watched
	input	wire logic			trig_out,
	input	wire logic			sync_out,
	input	wire logic [31:0]		phase_a,
	input	wire logic			show_synced,
	input	wire logic			show_unsynced,
	input	wire logic [1:0]		user_out,
	input	wire logic			relay_drive_out_a_oe,
	input	wire logic [2:0]		rise_act
);
	logic [6:0]	ctrl_r;
	logic [31:0]	docfg_r;
	logic		on_r;
	int		trig_cnt_r;
	int		show_cnt_r;
	wire logic	t_ev = transient_start & ctrl_r[0];
	wire logic	f_ev = (ctrl_r[1] & (dev_status.output_on ^ on_r)) | (ctrl_r[2] & (|setpt_chg));
	wire logic	pulse_mode = ctrl_r[3] & !ctrl_r[5];
	wire logic	active = sync_out ^ ctrl_r[4];

	// Arguments only, so the continuous assignment sees every change
	function automatic logic lvl(input logic [31:0] cfg, input aux_dio_pkg::dev_status_t ds, input int i);
		logic [7:0] v;
		v = {ds, cfg[16 + i]};
		return v[cfg[4 * i +: 3]] ^ cfg[4 * i + 3];
	endfunction
	wire logic [2:0] exp_lv = {lvl(docfg_r, dev_status, 2), lvl(docfg_r, dev_status, 1), lvl(docfg_r, dev_status, 0)};

	// Function width wins over transient width on a tie
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			trig_cnt_r <= 0;
		else if (f_ev)
			trig_cnt_r <= FUNC_CYC;
		else if (t_ev)
			trig_cnt_r <= TRANS_CYC;
		else if (trig_cnt_r != 0)
			trig_cnt_r <= trig_cnt_r - 1;
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= 7'h00;
			docfg_r <= 32'h0000_0000;
			on_r <= 1'b0;
			show_cnt_r <= 0;
		end else begin
			ctrl_r <= (wr && addr == aux_dio_pkg::CTRL_OFS) ? wdata[6:0] : ctrl_r;
			docfg_r <= (wr && addr == aux_dio_pkg::DO_CFG_OFS) ? wdata : docfg_r;
			on_r <= dev_status.output_on;
			show_cnt_r <= show_synced ? show_cnt_r + 1 : 0;
		end
	end

	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	AST_TRIG_TRANS: assert property (t_ev && !f_ev |=> trig_out)
		else $error("trigger missing after transient start");
	AST_TRIG_FUNC: assert property (f_ev |=> trig_out)
		else $error("trigger missing after function event");
	AST_TRIG_WIDTH: assert property (trig_out == (trig_cnt_r != 0))
		else $error("trigger width or source enable wrong");
	AST_SYNC_START: assert property (pulse_mode && $past(pulse_mode) && phase_a < $past(phase_a) |-> ##[0:3] active)
		else $error("sync pulse missing at phase zero");
	AST_SYNC_IDLE: assert property (!ctrl_r[3] && $stable(ctrl_r) |-> !active)
		else $error("sync output active while disabled");
	AST_SYNC_AUTO: assert property (ctrl_r[3] && ctrl_r[5] && $stable(ctrl_r) |-> active == !$past(phase_a[31]))
		else $error("square mode not following phase");
	AST_SHOW_EXCL: assert property (!(show_synced && show_unsynced))
		else $error("synced and unsynced shown together");
	AST_SHOW_OFF: assert property ((!ctrl_r[6])[*3] |-> !show_synced && !show_unsynced)
		else $error("sync status shown with sync input off");
	AST_SHOW_RUN: assert property (show_cnt_r <= SHOW_CYC)
		else $error("synced shown too long");
	AST_DO_LEVEL: assert property (user_out == $past(exp_lv[1:0]))
		else $error("user output level wrong");
	AST_RELAY_A: assert property (relay_drive_out_a_oe == !$past(exp_lv[2]))
		else $error("relay drive level wrong");

	cover property ($rose(trig_out));
	cover property ($rose(show_unsynced));
	cover property ($rose(show_synced));
	cover property ($rose(rise_act[0]));
endmodule // aux_dio_props

// file: aux_dio_far.sv
// Outside equipment: pulled-up relay lines and a TTL sync reference.
// Assumes the bench starts and stops the reference.
`timescale 1ns/1ns
module aux_dio_far #(
	parameter int REF_HALF_NS = 2560
) (
	// Relay coil drivers
	input	wire logic	a_oe,
	input	wire logic	b_oe,
	output	logic		a_lvl,
	output	logic		b_lvl,
	// Reference source
	input	wire logic	ref_en,
	output	logic		sync_ref
);
	// Released drain reads high through the internal pull-up
	assign a_lvl = !a_oe;
	assign b_lvl = !b_oe;
	initial begin
		sync_ref = 1'b0;
		forever begin
			#(REF_HALF_NS);
			sync_ref = ref_en & !sync_ref;
		end
	end
endmodule // aux_dio_far

// file: tb_aux_dio.sv
// Bench for the auxiliary digital I/O block: registers, strobe, sync, user I/O.
// Assumes shortened counts and aux_dio_far as the outside equipment.
`timescale 1ns/1ns
module tb_aux_dio;
	localparam int TC = 19;
	localparam int FC = 200;
	logic			mclk, rst_n, wr, rd, transient_start, ref_en, msel, mlvl, e;
	logic			trig_out, sync_out, show_synced, show_unsynced, sync_ref, ra_oe, rb_oe, ra_lvl, rb_lvl;
	logic [7:0]		addr, v;
	logic [31:0]		wdata, rdata, phase_a;
	logic [2:0]		user_in, rise_act, fall_act;
	logic [1:0]		user_out;
	logic [6:0]		ens [8] = '{7'h01, 7'h02, 7'h04, 7'h07, 7'h00, 7'h08, 7'h18, 7'h28};
	aux_dio_pkg::setpt_chg_t	setpt_chg;
	aux_dio_pkg::dev_status_t	dev_status;
	int			n_errors = 0, compares = 0, w, rise_n[3] = '{0, 0, 0}, fall_n[3] = '{0, 0, 0};
	wire logic		mon = msel ? sync_out : trig_out;

	aux_dio #(.TRANS_CYC(TC), .FUNC_CYC(FC), .SHOW_CYC(30), .BLINK_CYC(90), .LOSS_CYC(200), .US_CYC(100)) dut_u (
		.mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .transient_start, .setpt_chg, .dev_status,
		.sync_ref, .trig_out, .sync_out, .phase_a, .show_synced, .show_unsynced, .user_out,
		.relay_drive_out_a_o(), .relay_drive_out_a_oe(ra_oe), .relay_drive_out_b_o(),
		.relay_drive_out_b_oe(rb_oe), .user_in, .rise_act, .fall_act);
	aux_dio_far far_u (.a_oe(ra_oe), .b_oe(rb_oe), .a_lvl(ra_lvl), .b_lvl(rb_lvl), .ref_en, .sync_ref);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		for (int i = 0; i < 3; i++) begin
			rise_n[i] += rise_act[i];
			fall_n[i] += fall_act[i];
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	task automatic tick;
		@(posedge mclk);
		#1;
	endtask
	// Length of a run of mon at mlvl; align skips a partial run first
	task automatic run_len(input bit align);
		int k;
		k = 0;
		w = 0;
		#1;
		while (align && mon === mlvl && k++ < 3000) tick();
		while (align && mon !== mlvl && k++ < 3000) tick();
		while (mon === mlvl && w < 3000) begin
			w++;
			tick();
		end
	endtask
	task automatic wrap_up;
		$display("compares %0d, n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#500_000;
		n_errors++;
		wrap_up();
	end

	initial begin
		{rst_n, wr, rd, transient_start, ref_en, msel, mlvl} = '0;
		{addr, wdata, setpt_chg, dev_status, user_in} = '0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rchk(8'h04, 32'h0000_0064);
		rchk(8'h18, 32'h0000_0A7C);
		rchk(8'h1C, 32'h0000_01BF);
		wreg(8'h20, 32'hFFFF_FFFF);
		rchk(8'h20, 32'h0000_000F);
		wreg(8'h20, 32'h0000_0008);
		wreg(8'h14, 32'h1234_5678);
		rchk(8'h14, 32'h1234_5678);
		wreg(8'h2C, 32'hFFFF_FFFF);
		rchk(8'h2C, 32'h0000_0000);
		mlvl <= 1'b1;
		for (int j = 0; j < 5; j++) begin
			wreg(8'h00, {25'h0, ens[j]});
			for (int k = 0; k < 6; k++) begin
				@(posedge mclk);
				if (k == 0) transient_start <= 1'b1;
				else if (k == 5) dev_status.output_on <= !dev_status.output_on;
				else setpt_chg <= 4'h1 << (k - 1);
				@(posedge mclk);
				transient_start <= 1'b0;
				setpt_chg <= 4'h0;
				run_len(1'b0);
				chk(w, ens[j][k == 0 ? 0 : (k == 5 ? 1 : 2)] ? (k == 0 ? TC : FC) : 0);
			end
		end
		// Short phase period; width 1 us must clamp to 3 us
		wreg(8'h18, 32'h0080_0000);
		tick();
		w = phase_a;
		tick();
		chk(phase_a - w, 32'h0080_0000);
		wreg(8'h04, 32'h0000_0001);
		msel <= 1'b1;
		for (int j = 5; j < 8; j++) begin
			wreg(8'h00, {25'h0, ens[j]});
			mlvl <= !ens[j][4];
			run_len(1'b1);
			chk(w, ens[j][5] ? 256 : 300);
		end
		// Unsynced shown, synced not, while the engine is unlocked
		dev_status <= '0;
		wreg(8'h00, 32'h0000_0040);
		repeat (4) @(posedge mclk);
		#1;
		chk({show_synced, show_unsynced}, 2'b01);
		ref_en <= 1'b1;
		repeat (3000) @(posedge mclk);
		ref_en <= 1'b0;
		wreg(8'h00, 32'h0000_0000);
		for (int p = 0; p < 2; p++) begin
			dev_status <= p ? 7'h55 : 7'h2A;
			for (int s = 0; s < 16; s++) begin
				wreg(8'h08, {12'h000, {4{p[0]}}, {4{s[3:0]}}});
				repeat (2) @(posedge mclk);
				#1;
				v = {dev_status, p[0]};
				e = v[s[2:0]] ^ s[3];
				chk({rb_lvl, ra_lvl, user_out}, {4{e}});
			end
		end
		wreg(8'h10, 32'h0042_0301);
		wreg(8'h0C, 32'h0000_0002);
		// A 0.5 us glitch must not pass a 2 us filter
		user_in <= 3'b001;
		repeat (50) @(posedge mclk);
		user_in <= 3'b000;
		repeat (400) @(posedge mclk);
		user_in <= 3'b111;
		repeat (400) @(posedge mclk);
		chk({rise_n[0][3:0], rise_n[1][3:0], rise_n[2][3:0]}, 12'h101);
		user_in <= 3'b000;
		repeat (400) @(posedge mclk);
		chk({fall_n[0][3:0], fall_n[1][3:0], fall_n[2][3:0]}, 12'h011);
		rchk(8'h28, 32'h0000_0035);
		wrap_up();
	end
endmodule // tb_aux_dio

bind aux_dio aux_dio_props #(.TRANS_CYC(TRANS_CYC), .FUNC_CYC(FUNC_CYC), .SHOW_CYC(SHOW_CYC)) chk_u (
	.mclk, .rst_n, .addr, .wdata, .wr, .transient_start, .setpt_chg, .dev_status, .trig_out,
	.sync_out, .phase_a, .show_synced, .show_unsynced, .user_out, .relay_drive_out_a_oe, .rise_act);
